/* File: include/stbw_pkg.sv */
// constants for the system timebase and watchdog block
// assumes an sfr-style 8-bit register port with direct address decode
package stbw_pkg;
	localparam logic [7:0] SEC_INT_ADDR = 8'hf9;
	localparam logic [7:0] MS_INT_ADDR = 8'hfa;
	localparam logic [7:0] US_DIV_ADDR = 8'hfb;
	localparam logic [7:0] MS_DIV_LOW_ADDR = 8'hfc;
	localparam logic [7:0] MS_DIV_HIGH_ADDR = 8'hfd;
	localparam logic [7:0] TENTH_SEC_ADDR = 8'hfe;
	localparam logic [7:0] WD_CTRL_ADDR = 8'hff;
	localparam logic [6:0] SEC_INT_RESET = 7'h7f;
	localparam logic [6:0] MS_INT_RESET = 7'h7f;
	localparam logic [5:0] US_DIV_RESET = 6'h03;
	localparam logic [7:0] MS_DIV_LOW_RESET = 8'h9f;
	localparam logic [7:0] MS_DIV_HIGH_RESET = 8'h0f;
	localparam logic [7:0] TENTH_SEC_RESET = 8'h63;
	localparam logic [7:0] WD_CTRL_RESET = 8'h00;
	localparam int LOAD_NOW_BIT = 7;
	localparam int WD_ARM_BIT = 7;
	localparam int WD_DISARM_BIT = 6;
	localparam int WD_RESTART_BIT = 5;
	localparam int WD_COUNT_MSB = 4;
	localparam int IVL_MSB = 6;
	localparam int US_MSB = 5;
endpackage

/* File: hdl/stbw_divider.sv */
// reloadable up-counter divider: pulses once every (div+1) enabled ticks
// assumes div_in is stable or changes only between periods
`timescale 1ns/1ps
module stbw_divider #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic [WIDTH-1:0] div_in,
	output logic pulse_out
);
	initial begin
		if (WIDTH < 1 || WIDTH > 16) $error("stbw_divider width out of range");
	end
	logic [WIDTH-1:0] cnt_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_reg <= '0;
			pulse_out <= 1'b0;
		end else if (ce_in) begin
			pulse_out <= 1'b0;
			if (!run_in) begin
				cnt_reg <= '0;
			end else if (tick_in) begin
				if (cnt_reg >= div_in) begin
					cnt_reg <= '0;
					pulse_out <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule

/* File: hdl/stbw_interval.sv */
// interval timer: raises a sticky flag every (1+count) input ticks
// assumes one write strobe per cycle from the register port
`timescale 1ns/1ps
module stbw_interval (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	input wire logic rd_in,
	output logic [6:0] count_out,
	output logic flag_out
);
	logic [6:0] cnt_reg;
	logic pend_reg;
	logic expire;
	assign expire = run_in && tick_in && (cnt_reg >= count_out);
	// reload value
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_out <= stbw_pkg::SEC_INT_RESET;
			pend_reg <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && !wdata_in[stbw_pkg::LOAD_NOW_BIT]) begin
				pend_reg <= 1'b1;
			end else if (expire) begin
				pend_reg <= 1'b0;
			end
			if (wr_in) begin
				count_out <= wdata_in[stbw_pkg::IVL_MSB:0];
			end
		end
	end
	// running count; a delayed write keeps the old terminal until expiry
	logic [6:0] term_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_reg <= '0;
			term_reg <= stbw_pkg::SEC_INT_RESET;
		end else if (ce_in) begin
			if (wr_in && wdata_in[stbw_pkg::LOAD_NOW_BIT]) begin
				cnt_reg <= '0;
				term_reg <= wdata_in[stbw_pkg::IVL_MSB:0];
			end else if (!run_in) begin
				cnt_reg <= '0;
			end else if (tick_in) begin
				if (cnt_reg >= term_reg) begin
					cnt_reg <= '0;
					term_reg <= count_out;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
	// flag: set wins over read clear
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flag_out <= 1'b0;
		end else if (ce_in) begin
			if (run_in && tick_in && cnt_reg >= term_reg) begin
				flag_out <= 1'b1;
			end else if (rd_in) begin
				flag_out <= 1'b0;
			end
		end
	end
endmodule

/* File: hdl/stbw_timebase.sv */
// system timebase: us, ms and 100 ms ticks, ms and seconds interrupts, watchdog
// assumes a cpu sfr port: one-cycle read/write strobes with an 8-bit address
//
// Functional notes
// RULE1 - ms tick period is (high*256 + low + 1) system clocks
// RULE2 - 100 ms tick is the ms tick divided by tenth divider plus one
// RULE3 - us tick is the system clock divided by six-bit field plus one
// RULE4 - us tick drives flash write timer, ms tick drives flash erase timer
// RULE5 - seconds interrupt every (1+count) 100 ms ticks
// RULE6 - reading seconds interval clears seconds interrupt; visible via aux enable
// RULE7 - ms interrupt every (1+count) ms ticks
// RULE8 - software clears ms interrupt by reading register and clearing aux flag
// RULE9 - bit 7 picks delayed or immediate load; reads as zero
// RULE10 - writing bit 7 one then zero arms the watchdog
// RULE11 - writing bit 6 one then zero disarms the watchdog
// RULE12 - writing bit 5 one then zero restarts watchdog from zero
// RULE13 - enabled watchdog expires after count+1 to count+2 tenth ticks
// RULE14 - expiry resets system if reset select set, else raises interrupt
// RULE15 - power-down bits hold counters idle; both set after reset
`timescale 1ns/1ps
module stbw_timebase (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic wd_power_down_in,
	input wire logic systimer_power_down_in,
	input wire logic wd_reset_select_in,
	input wire logic aux_irq_flag_clr_in,
	output logic [7:0] sfr_rdata_out,
	output logic us_tick_out,
	output logic ms_tick_out,
	output logic tenth_tick_out,
	output logic sec_irq_out,
	output logic ms_irq_out,
	output logic aux_irq_flag_out,
	output logic wd_irq_out,
	output logic wd_sys_reset_out,
	output logic wd_counting_out
);
	logic [5:0] us_divider_reg;
	logic [7:0] ms_div_low_reg;
	logic [7:0] ms_div_high_reg;
	logic [7:0] tenth_sec_divider_reg;
	logic [7:0] watchdog_control_reg;
	logic st_run;
	logic wd_run;
	logic us_pulse;
	logic ms_pulse;
	logic tenth_pulse;
	logic [6:0] sec_count;
	logic [6:0] ms_count;
	logic sec_flag;
	logic ms_flag;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] want, input logic strobe);
		hit = strobe && (a == want);
	endfunction

	logic wr_sec, wr_ms, wr_wd, rd_sec, rd_ms;
	assign wr_sec = hit(sfr_addr_in, stbw_pkg::SEC_INT_ADDR, sfr_wr_in);
	assign wr_ms = hit(sfr_addr_in, stbw_pkg::MS_INT_ADDR, sfr_wr_in);
	assign wr_wd = hit(sfr_addr_in, stbw_pkg::WD_CTRL_ADDR, sfr_wr_in);
	assign rd_sec = hit(sfr_addr_in, stbw_pkg::SEC_INT_ADDR, sfr_rd_in);
	assign rd_ms = hit(sfr_addr_in, stbw_pkg::MS_INT_ADDR, sfr_rd_in);
	assign st_run = !systimer_power_down_in; // RULE15
	assign wd_run = !wd_power_down_in; // RULE15

	// divider registers
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			us_divider_reg <= stbw_pkg::US_DIV_RESET;
			ms_div_low_reg <= stbw_pkg::MS_DIV_LOW_RESET;
			ms_div_high_reg <= stbw_pkg::MS_DIV_HIGH_RESET;
			tenth_sec_divider_reg <= stbw_pkg::TENTH_SEC_RESET;
		end else if (ce_in && sfr_wr_in) begin
			case (sfr_addr_in)
				stbw_pkg::US_DIV_ADDR: us_divider_reg <= sfr_wdata_in[stbw_pkg::US_MSB:0];
				stbw_pkg::MS_DIV_LOW_ADDR: ms_div_low_reg <= sfr_wdata_in;
				stbw_pkg::MS_DIV_HIGH_ADDR: ms_div_high_reg <= sfr_wdata_in;
				stbw_pkg::TENTH_SEC_ADDR: tenth_sec_divider_reg <= sfr_wdata_in;
				default: ;
			endcase
		end
	end

	stbw_divider #(.WIDTH(6)) u_us_div ( // RULE3
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.run_in(st_run),
		.tick_in(1'b1),
		.div_in(us_divider_reg),
		.pulse_out(us_pulse)
	);

	stbw_divider #(.WIDTH(16)) u_ms_div ( // RULE1
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.run_in(st_run),
		.tick_in(1'b1),
		.div_in({ms_div_high_reg, ms_div_low_reg}),
		.pulse_out(ms_pulse)
	);

	// cascading keeps one divider chain; tenth tick lags ms tick by one cycle
	stbw_divider #(.WIDTH(8)) u_tenth_div ( // RULE2
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.run_in(st_run),
		.tick_in(ms_pulse),
		.div_in(tenth_sec_divider_reg),
		.pulse_out(tenth_pulse)
	);

	stbw_interval u_sec ( // RULE5 RULE9
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.run_in(st_run),
		.tick_in(tenth_pulse),
		.wr_in(wr_sec),
		.wdata_in(sfr_wdata_in),
		.rd_in(rd_sec), // RULE6
		.count_out(sec_count),
		.flag_out(sec_flag)
	);

	stbw_interval u_ms ( // RULE7 RULE9
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.run_in(st_run),
		.tick_in(ms_pulse),
		.wr_in(wr_ms),
		.wdata_in(sfr_wdata_in),
		.rd_in(rd_ms),
		.count_out(ms_count),
		.flag_out(ms_flag)
	);

	// registered tick and interrupt outputs; us and ms ticks feed the flash timers
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			us_tick_out <= 1'b0;
			ms_tick_out <= 1'b0;
			tenth_tick_out <= 1'b0;
			sec_irq_out <= 1'b0;
			ms_irq_out <= 1'b0;
		end else if (ce_in) begin
			us_tick_out <= us_pulse; // RULE4
			ms_tick_out <= ms_pulse; // RULE4
			tenth_tick_out <= tenth_pulse;
			sec_irq_out <= sec_flag; // RULE6
			ms_irq_out <= ms_flag;
		end
	end

	// aux flag: set by either interval event, cleared by software; set wins
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			aux_irq_flag_out <= 1'b0;
		end else if (ce_in) begin
			if ((ms_flag && !ms_irq_out) || (sec_flag && !sec_irq_out)) begin
				aux_irq_flag_out <= 1'b1;
			end else if (aux_irq_flag_clr_in) begin
				aux_irq_flag_out <= 1'b0; // RULE8
			end
		end
	end

	// watchdog control register and one-then-zero sequence detection
	logic arm_seq, disarm_seq, restart_seq;
	assign arm_seq = wr_wd && watchdog_control_reg[stbw_pkg::WD_ARM_BIT] && !sfr_wdata_in[stbw_pkg::WD_ARM_BIT];
	assign disarm_seq = wr_wd && watchdog_control_reg[stbw_pkg::WD_DISARM_BIT]
		&& !sfr_wdata_in[stbw_pkg::WD_DISARM_BIT];
	assign restart_seq = wr_wd && watchdog_control_reg[stbw_pkg::WD_RESTART_BIT]
		&& !sfr_wdata_in[stbw_pkg::WD_RESTART_BIT];

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			watchdog_control_reg <= stbw_pkg::WD_CTRL_RESET;
		end else if (ce_in && wr_wd) begin
			watchdog_control_reg <= sfr_wdata_in;
		end
	end

	// a disarm in the same write as an arm wins, so software can always stop it
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_counting_out <= 1'b0;
		end else if (ce_in) begin
			if (disarm_seq) begin
				wd_counting_out <= 1'b0; // RULE11
			end else if (arm_seq) begin
				wd_counting_out <= 1'b1; // RULE10
			end
		end
	end

	// counts tenth ticks; first tick lands anywhere in its period, hence one count of slack
	logic [5:0] wd_cnt_reg;
	logic wd_expire;
	assign wd_expire = wd_run && wd_counting_out && tenth_pulse && !restart_seq
		&& (wd_cnt_reg >= {1'b0, watchdog_control_reg[stbw_pkg::WD_COUNT_MSB:0]} + 6'd1);
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_cnt_reg <= '0;
		end else if (ce_in) begin
			if (restart_seq || !wd_run || !wd_counting_out) begin
				wd_cnt_reg <= '0; // RULE12
			end else if (wd_expire) begin
				wd_cnt_reg <= '0;
			end else if (tenth_pulse) begin
				wd_cnt_reg <= wd_cnt_reg + 6'd1; // RULE13
			end
		end
	end

	// expiry outcome; irq is sticky until a restart or disarm sequence
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_irq_out <= 1'b0;
			wd_sys_reset_out <= 1'b0;
		end else if (ce_in) begin
			wd_sys_reset_out <= wd_expire && wd_reset_select_in; // RULE14
			if (wd_expire && !wd_reset_select_in) begin
				wd_irq_out <= 1'b1; // RULE14
			end else if (restart_seq || disarm_seq) begin
				wd_irq_out <= 1'b0;
			end
		end
	end

	// read data; load-timing bit reads zero
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (ce_in && sfr_rd_in) begin
			case (sfr_addr_in)
				stbw_pkg::SEC_INT_ADDR: sfr_rdata_out <= {1'b0, sec_count}; // RULE9
				stbw_pkg::MS_INT_ADDR: sfr_rdata_out <= {1'b0, ms_count};
				stbw_pkg::US_DIV_ADDR: sfr_rdata_out <= {2'b00, us_divider_reg};
				stbw_pkg::MS_DIV_LOW_ADDR: sfr_rdata_out <= ms_div_low_reg;
				stbw_pkg::MS_DIV_HIGH_ADDR: sfr_rdata_out <= ms_div_high_reg;
				stbw_pkg::TENTH_SEC_ADDR: sfr_rdata_out <= tenth_sec_divider_reg;
				stbw_pkg::WD_CTRL_ADDR: sfr_rdata_out <= watchdog_control_reg;
				default: sfr_rdata_out <= 8'h00;
			endcase
		end
	end
endmodule

/* File: verification/stbw_timebase_assertions.sv */
// concurrent checks on the timebase and watchdog block ports
// assumes a bind to stbw_timebase with one clock domain
`timescale 1ns/1ps
module stbw_timebase_assertions (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic systimer_power_down_in,
	input wire logic wd_reset_select_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic us_tick_out,
	input wire logic ms_tick_out,
	input wire logic tenth_tick_out,
	input wire logic sec_irq_out,
	input wire logic wd_irq_out,
	input wire logic wd_sys_reset_out,
	input wire logic wd_counting_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// an access counts only with ce high
	wire wd_wr = sfr_wr_in && ce_in && sfr_addr_in == 8'hff;
	wire sec_rd = sfr_rd_in && ce_in && sfr_addr_in == 8'hf9;
	wire ivl_rd = sfr_rd_in && ce_in && (sfr_addr_in == 8'hf9 || sfr_addr_in == 8'hfa);
	property p_tenth_after_ms; tenth_tick_out |-> $past(ms_tick_out); endproperty
	a_tenth_after_ms: assert property (p_tenth_after_ms) else $error("tenth tick without ms tick");
	property p_st_idle; systimer_power_down_in [*3] |-> !(us_tick_out || ms_tick_out || tenth_tick_out); endproperty
	a_st_idle: assert property (p_st_idle) else $error("tick while powered down");
	property p_ivl_msb; ivl_rd |=> !sfr_rdata_out[7]; endproperty
	a_ivl_msb: assert property (p_ivl_msb) else $error("load bit read as one");
	// slack for a fresh expiry, since a set beats the read clear
	property p_sec_clr; sec_rd |-> ##3 (!sec_irq_out || $past(tenth_tick_out) || $past(tenth_tick_out, 2)
		|| $past(tenth_tick_out, 3) || $past(tenth_tick_out, 4)); endproperty
	a_sec_clr: assert property (p_sec_clr) else $error("seconds flag kept after read");
	property p_arm_src; $rose(wd_counting_out) |-> $past(wd_wr && !sfr_wdata_in[7]); endproperty
	a_arm_src: assert property (p_arm_src) else $error("counting set without arm");
	property p_disarm_src; $fell(wd_counting_out) |-> $past(wd_wr && !sfr_wdata_in[6]); endproperty
	a_disarm_src: assert property (p_disarm_src) else $error("counting cleared without disarm");
	property p_sys_rst; wd_sys_reset_out |-> $past(wd_reset_select_in) ##1 !wd_sys_reset_out; endproperty
	a_sys_rst: assert property (p_sys_rst) else $error("bad system reset pulse");
	property p_wd_irq; $rose(wd_irq_out) |-> $past(wd_counting_out) && !$past(wd_reset_select_in); endproperty
	a_wd_irq: assert property (p_wd_irq) else $error("bad watchdog interrupt");
endmodule
bind stbw_timebase stbw_timebase_assertions u_chk (.ref_clk_in, .resetn_in, .ce_in, .sfr_addr_in, .sfr_wr_in,
	.sfr_rd_in, .sfr_wdata_in, .systimer_power_down_in, .wd_reset_select_in, .sfr_rdata_out, .us_tick_out,
	.ms_tick_out, .tenth_tick_out, .sec_irq_out, .wd_irq_out, .wd_sys_reset_out, .wd_counting_out);

/* File: verification/tb_stbw_timebase.sv */
// self-checking bench for the timebase and watchdog block
// assumes one-cycle sfr strobes and read data the cycle after
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_stbw_timebase;
	logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic wd_pd = 1'b1, st_pd = 1'b1, wd_sel = 1'b0, aux_clr = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic us_t, ms_t, tn_t, sec_irq, ms_irq, aux_f, wd_irq, wd_rst, wd_cnt;
	int error_cnt = 0, n_tests = 0, cyc = 0, i;
	localparam logic [7:0] RST_TAB [7] = '{8'h7f, 8'h7f, 8'h03, 8'h9f, 8'h0f, 8'h63, 8'h00};
	wire [6:0] ev = {wd_rst, wd_irq, ms_irq, sec_irq, tn_t, ms_t, us_t};
	stbw_timebase u_stbw_timebase (.ref_clk_in(clk), .resetn_in(resetn), .ce_in(ce), .sfr_addr_in(addr),
		.sfr_wr_in(wr_s), .sfr_rd_in(rd_s), .sfr_wdata_in(wdata), .wd_power_down_in(wd_pd),
		.systimer_power_down_in(st_pd), .wd_reset_select_in(wd_sel), .aux_irq_flag_clr_in(aux_clr),
		.sfr_rdata_out(rdata), .us_tick_out(us_t), .ms_tick_out(ms_t), .tenth_tick_out(tn_t),
		.sec_irq_out(sec_irq), .ms_irq_out(ms_irq), .aux_irq_flag_out(aux_f), .wd_irq_out(wd_irq),
		.wd_sys_reset_out(wd_rst), .wd_counting_out(wd_cnt));
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic conclude;
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		`CHK($sformatf("reg %0h", a), e, rdata)
	endtask
	// strobe bits set, then cleared with the count kept
	task automatic wd_seq(input logic [7:0] d);
		wr(8'hff, d);
		wr(8'hff, d & 8'h1f);
	endtask
	// a level already high must fall first, so sticky flags need a clear
	task automatic wait_rise(input int w);
		logic p;
		int k;
		p = 1'b1;
		for (k = 0; k < 3000; k++) begin
			@(negedge clk);
			if (ev[w] === 1'b1 && p === 1'b0) break;
			p = ev[w];
		end
		if (k == 3000) `CHK("rise wait", 1'b1, 1'b0)
	endtask
	task automatic gap(input int w, input logic [7:0] a, input logic [7:0] rv, input int e);
		int t0;
		wait_rise(w);
		t0 = cyc;
		if (a !== 8'h00) rd(a, rv);
		wait_rise(w);
		`CHK($sformatf("period %0d", w), e, cyc - t0)
	endtask
	// count 2 at a 10-cycle tenth tick: 30 to 40 cycles plus latency
	task automatic wd_span(input int w);
		int t0;
		t0 = cyc;
		wait_rise(w);
		`CHK("wd span", 1'b1, cyc - t0 >= 29 && cyc - t0 <= 44)
	endtask
	task automatic chk_reset;
		for (i = 0; i < 7; i++) rd(8'hf9 + i[7:0], RST_TAB[i]);
		rd(8'hf0, 8'h00);
	endtask
	initial begin
		#100us;
		`CHK("watchdog", 1'b1, 1'b0)
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		chk_reset();
		wr(8'hfb, 8'hc1);
		rd(8'hfb, 8'h01);
		// clock enable low must freeze the register file, so this write is lost
		@(posedge clk);
		ce <= 1'b0;
		wr(8'hfb, 8'h05);
		@(posedge clk);
		ce <= 1'b1;
		rd(8'hfb, 8'h01);
		wr(8'hfc, 8'h04);
		wr(8'hfd, 8'h00);
		wr(8'hfe, 8'h01);
		@(posedge clk);
		st_pd <= 1'b0;
		wd_pd <= 1'b0;
		gap(0, 8'h00, 8'h00, 2);
		gap(1, 8'h00, 8'h00, 5);
		gap(2, 8'h00, 8'h00, 10);
		wr(8'hfd, 8'h01);
		gap(1, 8'h00, 8'h00, 261);
		wr(8'hfd, 8'h00);
		wr(8'hfa, 8'h82);
		rd(8'hfa, 8'h02);
		gap(4, 8'hfa, 8'h02, 15);
		rd(8'hfa, 8'h02);
		@(posedge clk);
		aux_clr <= 1'b1;
		@(posedge clk);
		aux_clr <= 1'b0;
		@(negedge clk);
		`CHK("ms irq", 1'b0, ms_irq)
		`CHK("aux flag", 1'b0, aux_f)
		wr(8'hfa, 8'h04);
		gap(4, 8'hfa, 8'h04, 25);
		wr(8'hf9, 8'h81);
		rd(8'hf9, 8'h01);
		gap(3, 8'hf9, 8'h01, 20);
		wd_seq(8'h82);
		@(negedge clk);
		`CHK("wd armed", 1'b1, wd_cnt)
		wd_span(5);
		wd_seq(8'h22);
		@(negedge clk);
		`CHK("wd irq", 1'b0, wd_irq)
		wd_span(5);
		@(posedge clk);
		wd_sel <= 1'b1;
		wd_seq(8'h22);
		wd_span(6);
		@(posedge clk);
		wd_sel <= 1'b0;
		wd_pd <= 1'b1;
		wd_seq(8'h22);
		repeat (60) @(negedge clk);
		`CHK("wd held", 1'b0, wd_irq)
		wd_seq(8'h42);
		@(negedge clk);
		`CHK("wd disarmed", 1'b0, wd_cnt)
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		chk_reset();
		conclude();
	end
endmodule
